// File: design/cfr_routing_top.sv
// Purpose: Control and routing for CAN acceptance filters 4 to 19
// Assumes: AXI4-Lite slave, synchronous reset, 20 MHz core clock
// Notes:   Filter compare values come from the receive path
// Operation
// RL1 - Each filter has one enable bit; off means it accepts nothing.
// RL2 - Two-bit mask choice picks acceptance mask 0 to 3 by value.
// RL3 - Five-bit FIFO choice names the FIFO that stores matched messages.
// RL4 - Mask and FIFO choice change only while the filter is off.
// RL5 - Byte layout: enable bit 7, mask choice 6:5, FIFO choice 4:0.
// RL6 - Four filters per register, lowest filter in bits 7:0.
// RL7 - Registers one to four hold filters 4-7, 8-11, 12-15, 16-19.
// RL8 - All fields read/write and reset to zero.
// RL9 - Selected mask decides which identifier bits are compared.
// RL10 - Writes to choices of an enabled filter are dropped; enable stays. The code still writes the enable bit of an enabled filter.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cfr_routing_top
    import cfr_pkg::*;
#(
    parameter int unsigned NUM_FLT = CFR_NUM_FLT,
    parameter int unsigned ID_W    = CFR_ID_W
)(
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST,
    input  wire logic [7:0]              AWADDR,
    input  wire logic                    AWVALID,
    output logic                         AWREADY,
    input  wire logic [31:0]             WDATA,
    input  wire logic [3:0]              WSTRB,
    input  wire logic                    WVALID,
    output logic                         WREADY,
    output logic [1:0]                   BRESP,
    output logic                         BVALID,
    input  wire logic                    BREADY,
    input  wire logic [7:0]              ARADDR,
    input  wire logic                    ARVALID,
    output logic                         ARREADY,
    output logic [31:0]                  RDATA,
    output logic [1:0]                   RRESP,
    output logic                         RVALID,
    input  wire logic                    RREADY,
    input  wire logic                    MSG_VALID,
    input  wire logic [ID_W-1:0]         MSG_ID,
    input  wire logic [NUM_FLT*ID_W-1:0] FLT_ID,
    output logic                         MSG_HIT,
    output logic [4:0]                   MSG_FIFO,
    output logic [3:0]                   MSG_FILTER,
    output logic [NUM_FLT-1:0]           FILTER_ON,
    output logic [NUM_FLT*2-1:0]         MASK_CHOICE,
    output logic [NUM_FLT*5-1:0]         FIFO_CHOICE
);
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;

    logic [7:0]      flt_ff  [NUM_FLT];
    logic [7:0]      nxt_flt [NUM_FLT];
    logic [ID_W-1:0] mask_ff  [4];
    logic [ID_W-1:0] nxt_mask [4];
    logic [NUM_FLT-1:0] hit;
    logic        hit_ff, nxt_hit;
    logic [4:0]  fifo_ff, nxt_fifo;
    logic [3:0]  fidx_ff, nxt_fidx;

    cfr_axil_slave u_bus (
        .clk     (CORE_CLK),
        .rst     (RST),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode: groups at 0x00..0x0c, masks at 0x10..0x1c
    logic       wr_grp, wr_msk, rd_grp, rd_msk;
    logic [1:0] wr_idx, rd_idx;
    assign wr_idx = wr_addr[3:2];
    assign rd_idx = rd_addr[3:2];
    assign wr_grp = (wr_addr[7:4] == CFR_OFS_GROUP1[7:4]) && !wr_addr[1]
                    && !wr_addr[0];
    assign wr_msk = (wr_addr[7:4] == CFR_OFS_MASK0[7:4]) && !wr_addr[1]
                    && !wr_addr[0];
    assign rd_grp = (rd_addr[7:4] == CFR_OFS_GROUP1[7:4]) && !rd_addr[1]
                    && !rd_addr[0];
    assign rd_msk = (rd_addr[7:4] == CFR_OFS_MASK0[7:4]) && !rd_addr[1]
                    && !rd_addr[0];
    assign wr_err = !(wr_grp || wr_msk);
    assign rd_err = !(rd_grp || rd_msk);

    ////////////////////////////////////////////////////////////////////////
    // Filter bytes
    genvar g;
    generate
        for (g = 0; g < NUM_FLT; g++) begin : g_flt
            always_comb begin
                nxt_flt[g] = flt_ff[g];
                // RL6 RL7 byte placement
                if (wr_stb && wr_grp && (wr_idx == 2'(g / 4))
                    && wr_strb[g % 4]) begin
                    // RL1 enable always writable
                    nxt_flt[g][CFR_ON_BIT] = wr_data[(g % 4) * 8 + 7];
                    // RL4 RL10 choices locked while on
                    if (!flt_ff[g][CFR_ON_BIT]) begin
                        nxt_flt[g][CFR_MSEL_HI:CFR_FSEL_LO] =
                            wr_data[(g % 4) * 8 +: 7];
                    end
                end
            end
            // RL8 reset to zero
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    flt_ff[g] <= CFR_FLT_RESET;
                end else begin
                    flt_ff[g] <= nxt_flt[g];
                end
            end
            // RL5 field layout
            assign FILTER_ON[g]       = flt_ff[g][CFR_ON_BIT];
            assign MASK_CHOICE[g*2 +: 2] = flt_ff[g][CFR_MSEL_HI:CFR_MSEL_LO];
            assign FIFO_CHOICE[g*5 +: 5] = flt_ff[g][CFR_FSEL_HI:CFR_FSEL_LO];
            // RL2 RL9 mask by choice
            cfr_flt_match #(.ID_W(ID_W)) u_match (
                .on     (flt_ff[g][CFR_ON_BIT]),
                .msg_id (MSG_ID),
                .flt_id (FLT_ID[g*ID_W +: ID_W]),
                .mask   (mask_ff[flt_ff[g][CFR_MSEL_HI:CFR_MSEL_LO]]),
                .hit    (hit[g])
            );
        end
        for (g = 0; g < 4; g++) begin : g_mask
            always_comb begin
                nxt_mask[g] = mask_ff[g];
                if (wr_stb && wr_msk && (wr_idx == 2'(g))) begin
                    nxt_mask[g] = wr_data[ID_W-1:0];
                end
            end
            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    mask_ff[g] <= CFR_MASK_RESET[ID_W-1:0];
                end else begin
                    mask_ff[g] <= nxt_mask[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read mux; upper mask bits read as zero
    always_comb begin
        rd_data = 32'h00000000;
        if (rd_grp) begin
            for (int i = 0; i < 4; i++) begin
                rd_data[i*8 +: 8] = flt_ff[rd_idx*4 + i];
            end
        end else if (rd_msk) begin
            rd_data[ID_W-1:0] = mask_ff[rd_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing: lowest numbered hit wins, result one cycle later
    always_comb begin
        nxt_hit  = 1'b0;
        nxt_fifo = 5'h00;
        nxt_fidx = 4'h0;
        if (MSG_VALID) begin
            for (int i = NUM_FLT - 1; i >= 0; i--) begin
                if (hit[i]) begin
                    nxt_hit  = 1'b1;
                    // RL3 FIFO from choice
                    nxt_fifo = flt_ff[i][CFR_FSEL_HI:CFR_FSEL_LO];
                    nxt_fidx = 4'(i);
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            hit_ff  <= 1'b0;
            fifo_ff <= 5'h00;
            fidx_ff <= 4'h0;
        end else begin
            hit_ff  <= nxt_hit;
            fifo_ff <= nxt_fifo;
            fidx_ff <= nxt_fidx;
        end
    end

    assign MSG_HIT    = hit_ff;
    assign MSG_FIFO   = fifo_ff;
    assign MSG_FILTER = fidx_ff;
endmodule
`default_nettype wire

// File: design/cfr_pkg.sv
// Purpose: Shared constants for the CAN filter routing block
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package cfr_pkg;
    localparam int unsigned  CFR_FIRST_FLT    = 4;
    localparam int unsigned  CFR_NUM_FLT      = 16;
    localparam int unsigned  CFR_NUM_REG      = 4;
    localparam logic [7:0]   CFR_OFS_GROUP1   = 8'h00;
    localparam logic [7:0]   CFR_OFS_GROUP2   = 8'h04;
    localparam logic [7:0]   CFR_OFS_GROUP3   = 8'h08;
    localparam logic [7:0]   CFR_OFS_GROUP4   = 8'h0c;
    localparam logic [7:0]   CFR_OFS_MASK0    = 8'h10;
    localparam int unsigned  CFR_ON_BIT       = 7;
    localparam int unsigned  CFR_MSEL_HI      = 6;
    localparam int unsigned  CFR_MSEL_LO      = 5;
    localparam int unsigned  CFR_FSEL_HI      = 4;
    localparam int unsigned  CFR_FSEL_LO      = 0;
    localparam logic [7:0]   CFR_FLT_RESET    = 8'h00;
    localparam logic [31:0]  CFR_MASK_RESET   = 32'h00000000;
    localparam logic [1:0]   CFR_RESP_OKAY    = 2'b00;
    localparam logic [1:0]   CFR_RESP_SLVERR  = 2'b10;
    localparam int unsigned  CFR_ID_W         = 29;
endpackage

// File: design/cfr_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Same clock as the register file
// Notes:   Write answers two cycles after both channels are taken
`timescale 1ns/10ps
`default_nettype none
module cfr_axil_slave
    import cfr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_stb,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [7:0]  awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [3:0]  ws_ff, nxt_ws;
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;

    ////////////////////////////////////////////////////////////////////////
    // Hold each channel until both are in; no new write before bready
    assign awready = !aw_ff && !b_ff;
    assign wready  = !w_ff && !b_ff;
    assign arready = !r_ff;
    assign wr_stb  = aw_ff && w_ff;
    assign wr_addr = awa_ff;
    assign wr_data = wd_ff;
    assign wr_strb = ws_ff;
    assign rd_addr = araddr;
    assign bvalid  = b_ff;
    assign bresp   = br_ff;
    assign rvalid  = r_ff;
    assign rdata   = rd_ff;
    assign rresp   = rr_ff;

    always_comb begin
        nxt_aw  = aw_ff;
        nxt_w   = w_ff;
        nxt_b   = b_ff;
        nxt_awa = awa_ff;
        nxt_wd  = wd_ff;
        nxt_ws  = ws_ff;
        nxt_br  = br_ff;
        nxt_r   = r_ff;
        nxt_rd  = rd_ff;
        nxt_rr  = rr_ff;
        if (awvalid && awready) begin
            nxt_aw  = 1'b1;
            nxt_awa = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w  = 1'b1;
            nxt_wd = wdata;
            nxt_ws = wstrb;
        end
        if (wr_stb) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_b  = 1'b1;
            nxt_br = wr_err ? CFR_RESP_SLVERR : CFR_RESP_OKAY;
        end
        if (b_ff && bready) begin
            nxt_b = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_r  = 1'b1;
            nxt_rd = rd_err ? 32'h00000000 : rd_data;
            nxt_rr = rd_err ? CFR_RESP_SLVERR : CFR_RESP_OKAY;
        end else if (r_ff && rready) begin
            nxt_r = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_ff  <= 1'b0;
            w_ff   <= 1'b0;
            b_ff   <= 1'b0;
            r_ff   <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff  <= 32'h00000000;
            ws_ff  <= 4'h0;
            br_ff  <= 2'h0;
            rd_ff  <= 32'h00000000;
            rr_ff  <= 2'h0;
        end else begin
            aw_ff  <= nxt_aw;
            w_ff   <= nxt_w;
            b_ff   <= nxt_b;
            r_ff   <= nxt_r;
            awa_ff <= nxt_awa;
            wd_ff  <= nxt_wd;
            ws_ff  <= nxt_ws;
            br_ff  <= nxt_br;
            rd_ff  <= nxt_rd;
            rr_ff  <= nxt_rr;
        end
    end
endmodule
`default_nettype wire

// File: design/cfr_flt_match.sv
// Purpose: One acceptance filter compare under a selected mask
// Assumes: Identifier and filter value from the receive path
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module cfr_flt_match
    import cfr_pkg::*;
#(
    parameter int unsigned ID_W = CFR_ID_W
)(
    input  wire logic            on,
    input  wire logic [ID_W-1:0] msg_id,
    input  wire logic [ID_W-1:0] flt_id,
    input  wire logic [ID_W-1:0] mask,
    output logic                 hit
);
    // Mask one includes the bit, zero makes it don't care
    assign hit = on && (((msg_id ^ flt_id) & mask) == '0);
endmodule
`default_nettype wire

// File: tb/cfr_rx_model.sv
// Purpose: Receive path stand-in offering identifiers and filter values
// Assumes: Bench raises send for one cycle per message
// Notes:   Identifier is inverted while idle so a stale one differs in every bit
`timescale 1ns/10ps
`default_nettype none
module cfr_rx_model
    import cfr_pkg::*;
#(
    parameter int unsigned NUM_FLT = CFR_NUM_FLT,
    parameter int unsigned ID_W    = CFR_ID_W
)(
    input  wire logic                    clk,
    input  wire logic                    send,
    input  wire logic [ID_W-1:0]         id,
    input  wire logic [NUM_FLT*ID_W-1:0] flt,
    output logic                         msg_valid,
    output logic [ID_W-1:0]              msg_id,
    output logic [NUM_FLT*ID_W-1:0]      flt_id
);
    always_ff @(posedge clk) begin
        msg_valid <= send;
        msg_id    <= send ? id : ~id;
        flt_id    <= flt;
    end
endmodule
`default_nettype wire

// File: tb/cfr_routing_chk.sv
// Purpose: Bus and routing checks on the filter routing top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every instance of the top
`timescale 1ns/10ps
`default_nettype none
module cfr_routing_chk
    import cfr_pkg::*;
#(
    parameter int unsigned NUM_FLT = CFR_NUM_FLT
)(
    input wire logic                 CORE_CLK,
    input wire logic                 RST,
    input wire logic                 AWVALID,
    input wire logic                 AWREADY,
    input wire logic                 WVALID,
    input wire logic                 WREADY,
    input wire logic [1:0]           BRESP,
    input wire logic                 BVALID,
    input wire logic                 BREADY,
    input wire logic                 ARVALID,
    input wire logic                 ARREADY,
    input wire logic [31:0]          RDATA,
    input wire logic                 RVALID,
    input wire logic                 RREADY,
    input wire logic                 MSG_VALID,
    input wire logic                 MSG_HIT,
    input wire logic [4:0]           MSG_FIFO,
    input wire logic [3:0]           MSG_FILTER,
    input wire logic [NUM_FLT-1:0]   FILTER_ON,
    input wire logic [NUM_FLT*2-1:0] MASK_CHOICE,
    input wire logic [NUM_FLT*5-1:0] FIFO_CHOICE
);
    logic [NUM_FLT*7-1:0] sel_ff;
    logic [NUM_FLT-1:0]   on_ff;
    logic [NUM_FLT*7-1:0] lock;
    ////////////////////////////////////////////////////////////
    // Copies one cycle old, since the match answer is registered
    always_ff @(posedge CORE_CLK) begin
        sel_ff <= {MASK_CHOICE, FIFO_CHOICE};
        on_ff  <= FILTER_ON;
    end
    always_comb begin
        for (int i = 0; i < NUM_FLT; i++) begin
            lock[i*5 +: 5]           = {5{FILTER_ON[i]}};
            lock[NUM_FLT*5+i*2 +: 2] = {2{FILTER_ON[i]}};
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    a_reset_clears: assert property ($fell(RST) |->
        FILTER_ON == '0 && MASK_CHOICE == '0 && FIFO_CHOICE == '0)
        else $error("fields not clear after reset");
    // Answer comes after the internal strobe cycle
    a_write_answer: assert property (
        AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID)
        else $error("no write response");
    a_resp_holds: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("new write taken while busy");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("no read data");
    a_rdata_holds: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    a_hit_needs_on: assert property (
        MSG_HIT |-> $past(MSG_VALID) && on_ff[MSG_FILTER])
        else $error("hit without offer or enabled filter");
    a_route_fifo: assert property (
        MSG_HIT |-> MSG_FIFO == sel_ff[int'(MSG_FILTER)*5 +: 5])
        else $error("hit routed to wrong fifo");
    a_choice_locked: assert property (
        (({MASK_CHOICE, FIFO_CHOICE} ^ sel_ff) & $past(lock)) == '0)
        else $error("choice of enabled filter changed");
    c_hit: cover property (MSG_HIT);
    c_slverr: cover property (BVALID && BRESP == CFR_RESP_SLVERR);
    c_read: cover property (RVALID && RREADY);
endmodule
bind cfr_routing_top cfr_routing_chk #(.NUM_FLT(NUM_FLT)) u_chk (
    .CORE_CLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
    .MSG_VALID, .MSG_HIT, .MSG_FIFO, .MSG_FILTER, .FILTER_ON,
    .MASK_CHOICE, .FIFO_CHOICE
);
`default_nettype wire

// File: tb/test_can_acceptance_filter_routing.sv
// Purpose: Self-checking bench for the filter routing block
// Assumes: Byte offsets of the package, one bus transfer at a time
// Notes:   Queue-free model of registers and masks kept in arrays
`timescale 1ns/10ps
`default_nettype none
module test_can_acceptance_filter_routing;
    import cfr_pkg::*;
    logic CORE_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, MSG_VALID, MSG_HIT, send;
    logic [7:0]                    AWADDR, ARADDR, ad;
    logic [31:0]                   WDATA, RDATA, MASK_CHOICE;
    logic [3:0]                    WSTRB, MSG_FILTER;
    logic [1:0]                    BRESP, RRESP;
    logic [4:0]                    MSG_FIFO;
    logic [15:0]                   FILTER_ON;
    logic [79:0]                   FIFO_CHOICE;
    logic [CFR_ID_W-1:0]           MSG_ID, id;
    logic [CFR_NUM_FLT*CFR_ID_W-1:0] FLT_ID, flt;
    logic [31:0]                   regs[4], masks[4];
    int                            miscompares, tests_run, k, sh;
    cfr_routing_top DUT (.*);
    cfr_rx_model u_rx (.clk(CORE_CLK), .send(send), .id(id), .flt(flt),
        .msg_valid(MSG_VALID), .msg_id(MSG_ID), .flt_id(FLT_ID));
    ////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_match(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t match %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] resp(input logic [7:0] a);
        return {30'h0, a < 8'h20 ? CFR_RESP_OKAY : CFR_RESP_SLVERR};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [7:0] o;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        cmp_word({30'h0, BRESP}, resp(a));
        // Mask words are written whole, strobes not applied
        if (a >= 8'h10 && a < 8'h20)
            masks[a[3:2]] = d;
        for (int b = 0; b < 4; b++) begin
            o = regs[a[3:2]][b*8 +: 8];
            if (s[b] && a < 8'h10 && o[7])
                regs[a[3:2]][b*8 +: 8] = {d[b*8+7], o[6:0]};
            else if (s[b] && a < 8'h10)
                regs[a[3:2]][b*8 +: 8] = d[b*8 +: 8];
        end
    endtask
    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        cmp_word(RDATA, a < 8'h10 ? regs[a[3:2]] : a < 8'h20 ?
                 masks[a[3:2]] & 32'h1fffffff : 32'h0);
        cmp_word({30'h0, RRESP}, resp(a));
    endtask
    task automatic msg(input logic [CFR_ID_W-1:0] v);
        logic [9:0] e;
        logic [7:0] c;
        e = 10'h0;
        for (int i = CFR_NUM_FLT - 1; i >= 0; i--) begin
            c = regs[i/4][(i%4)*8 +: 8];
            // mask picked by value, set mask bit compares
            if (c[7] && ((v ^ flt[i*CFR_ID_W +: CFR_ID_W])
                & masks[c[6:5]][CFR_ID_W-1:0]) == '0)
                e = {1'b1, c[4:0], 4'(i)};
        end
        id <= v;
        send <= 1'b1;
        @(posedge CORE_CLK);
        send <= 1'b0;
        @(posedge CORE_CLK);
        // Routing outputs read zero when nothing hits
        #1 cmp_match({MSG_HIT, MSG_FIFO, MSG_FILTER}, e);
        @(posedge CORE_CLK);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    // Run needs about 800 cycles; generous margin
    initial begin
        #1000000 miscompares++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h2ab8));
        {AWVALID, WVALID, ARVALID, send} = '0;
        // Master always ready for answers, so no double drive
        BREADY = 1'b1;
        RREADY = 1'b1;
        {AWADDR, ARADDR, WDATA, WSTRB, id} = '0;
        RST = 1'b1;
        for (int i = 0; i < CFR_NUM_FLT; i++) begin
            flt[i*CFR_ID_W +: CFR_ID_W] = CFR_ID_W'($urandom);
            regs[i/4] = 32'h0;
            masks[i/4] = 32'h0;
        end
        repeat (10) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        for (int a = 0; a < 9; a++) rd(8'(a * 4));
        wr(8'h20, 32'hffffffff, 4'hf);
        for (int i = 0; i < CFR_NUM_FLT; i++) begin
            ad = 8'(i / 4 * 4);
            sh = (i % 4) * 8;
            wr(ad, {24'h0, 1'b1, 2'(i), 5'(31 - i)} << sh,
               4'b1 << (i % 4));
            msg(flt[i*CFR_ID_W +: CFR_ID_W]);
            wr(ad, 32'h7f << sh, 4'hf);
            rd(ad);
            // filter already off from the write above, so its choices now clear
            wr(ad, 32'h0, 4'hf);
            rd(ad);
        end
        repeat (60) begin
            wr(8'($urandom_range(7)) << 2, $urandom, 4'($urandom));
            rd(8'($urandom_range(7)) << 2);
            k = $urandom_range(15);
            msg(flt[k*CFR_ID_W +: CFR_ID_W]
                ^ CFR_ID_W'($urandom & $urandom));
        end
        finish_test();
    end
endmodule
`default_nettype wire
